/* File: logic/awl_top.sv */
// Long-sector write command handler: takes the command, collects one
// sector with its check bytes, streams it to flash, posts the task file.
// Assumes task-file strobes and flash answers come from the same clock.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Codes 32h and 33h both start the same one-sector write.
// - Sector count from the host is ignored; exactly one sector is written.
// - Host sends 512 data then 4 check bytes; buffered, then programmed.
// - Drive/head low nibble is head or LBA 27:24; L selects LBA, D drive.
// - Cylinder high, cylinder low, sector number carry remaining address bytes.
// - Completion status 0,1,0,1 fixed bits; error reports only BBK, IDNF, AMNF.
// - Address registers hold the address given with the command at completion, error or not.
module awl_top (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // Task file from host logic
    input wire logic CMD_WR,
    input wire logic [7:0] CMD_CODE,
    input wire logic [7:0] DEV_HEAD,
    input wire logic [7:0] CYL_HI,
    input wire logic [7:0] CYL_LO,
    input wire logic [7:0] SEC_NUM,
    // Data phase
    input wire logic DATA_VALID,
    input wire logic [7:0] DATA_BYTE,
    // Flash programming
    output logic FL_START,
    output logic FL_LBA,
    output logic FL_DRIVE,
    output logic [27:0] FL_ADDR,
    output logic FL_VALID,
    output logic [7:0] FL_BYTE,
    input wire logic FL_DONE,
    input wire logic FL_BAD_BLOCK,
    input wire logic FL_ID_NF,
    input wire logic FL_AM_NF,
    // Completion task file
    output logic [7:0] STATUS,
    output logic [7:0] ERROR,
    output logic [7:0] TF_DEV_HEAD,
    output logic [7:0] TF_CYL_HI,
    output logic [7:0] TF_CYL_LO,
    output logic [7:0] TF_SEC_NUM,
    output logic [7:0] TF_SEC_CNT,
    output logic CMD_DONE
);
    typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_PROG, ST_WAIT} awl_state_e;

    awl_state_e state_q, state_d;
    logic [awl_pkg::BUF_AW-1:0] cnt_q, cnt_d;
    logic [7:0] dh_q, dh_d;
    logic [7:0] ch_q, ch_d;
    logic [7:0] cl_q, cl_d;
    logic [7:0] sn_q, sn_d;
    logic [7:0] sc_q, sc_d;
    logic [7:0] status_q, status_d;
    logic [7:0] error_q, error_d;
    logic start_q, start_d;
    logic rd_q, rd_d;
    logic fvalid_q, fvalid_d;
    logic [7:0] byte_q, byte_d;
    logic done_q, done_d;
    logic is_long;

    awl_buf_if buf_if ();

    awl_sector_buf #(
        .DEPTH(awl_pkg::XFER_BYTES)
    ) u_buf (
        .clk(CLK_SYS),
        .bus(buf_if)
    );

    assign is_long = (CMD_CODE == awl_pkg::CMD_LONG_RETRY) || (CMD_CODE == awl_pkg::CMD_LONG_NORETRY);

    // Buffer fill during data phase, sequential drain during programming
    assign buf_if.we = (state_q == ST_XFER) && DATA_VALID;
    assign buf_if.waddr = cnt_q;
    assign buf_if.wdata = DATA_BYTE;
    assign buf_if.raddr = cnt_q;

    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        dh_d = dh_q;
        ch_d = ch_q;
        cl_d = cl_q;
        sn_d = sn_q;
        sc_d = sc_q;
        error_d = error_q;
        start_d = 1'b0;
        rd_d = 1'b0;
        done_d = 1'b0;
        case (state_q)
            ST_IDLE:
            begin
                // Commands other than the two codes are left to other handlers
                if (CMD_WR && is_long)
                begin
                    dh_d = DEV_HEAD;
                    ch_d = CYL_HI;
                    cl_d = CYL_LO;
                    sn_d = SEC_NUM;
                    error_d = awl_pkg::ERROR_RST;
                    cnt_d = '0;
                    state_d = ST_XFER;
                end
            end
            ST_XFER:
            begin
                if (DATA_VALID)
                begin
                    if (cnt_q == awl_pkg::LAST_IDX)
                    begin
                        cnt_d = '0;
                        start_d = 1'b1;
                        state_d = ST_PROG;
                    end
                    else
                    begin
                        cnt_d = cnt_q + 1'b1;
                    end
                end
            end
            ST_PROG:
            begin
                rd_d = 1'b1;
                if (cnt_q == awl_pkg::LAST_IDX)
                begin
                    cnt_d = '0;
                    state_d = ST_WAIT;
                end
                else
                begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            ST_WAIT:
            begin
                if (FL_DONE)
                begin
                    error_d = awl_pkg::ERROR_RST;
                    error_d[awl_pkg::ER_BBK] = FL_BAD_BLOCK;
                    error_d[awl_pkg::ER_IDNF] = FL_ID_NF;
                    error_d[awl_pkg::ER_AMNF] = FL_AM_NF;
                    sc_d = (FL_BAD_BLOCK || FL_ID_NF || FL_AM_NF) ? 8'h01 : 8'h00;
                    done_d = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
        fvalid_d = rd_q;
        // Re-time buffer read data so each byte lines up with its valid
        byte_d = buf_if.rdata;

        // Status follows the next state so it lines up with it
        status_d = awl_pkg::STATUS_RST;
        status_d[awl_pkg::ST_BSY] = (state_d == ST_PROG) || (state_d == ST_WAIT) || ((state_d == ST_IDLE) && rd_q);
        status_d[awl_pkg::ST_DRQ] = (state_d == ST_XFER);
        status_d[awl_pkg::ST_ERR] = |error_d;
    end

    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
            dh_q <= awl_pkg::TF_RST;
            ch_q <= awl_pkg::TF_RST;
            cl_q <= awl_pkg::TF_RST;
            sn_q <= awl_pkg::TF_RST;
            sc_q <= awl_pkg::TF_RST;
            status_q <= awl_pkg::STATUS_RST;
            error_q <= awl_pkg::ERROR_RST;
            start_q <= 1'b0;
            rd_q <= 1'b0;
            fvalid_q <= 1'b0;
            byte_q <= 8'h00;
            done_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            dh_q <= dh_d;
            ch_q <= ch_d;
            cl_q <= cl_d;
            sn_q <= sn_d;
            sc_q <= sc_d;
            status_q <= status_d;
            error_q <= error_d;
            start_q <= start_d;
            rd_q <= rd_d;
            fvalid_q <= fvalid_d;
            byte_q <= byte_d;
            done_q <= done_d;
        end
    end

    assign FL_START = start_q;
    assign FL_LBA = dh_q[awl_pkg::DH_LBA_BIT];
    assign FL_DRIVE = dh_q[awl_pkg::DH_DRV_BIT];
    assign FL_ADDR = {dh_q[3:0], ch_q, cl_q, sn_q};
    assign FL_VALID = fvalid_q;
    assign FL_BYTE = byte_q;
    assign STATUS = status_q;
    assign ERROR = error_q;
    assign TF_DEV_HEAD = dh_q;
    assign TF_CYL_HI = ch_q;
    assign TF_CYL_LO = cl_q;
    assign TF_SEC_NUM = sn_q;
    assign TF_SEC_CNT = sc_q;
    assign CMD_DONE = done_q;
endmodule : awl_top

`default_nettype wire

/* File: logic/awl_pkg.sv */
// Constants for the long-sector write command handler.
// Assumes a single system clock shared with the task-file logic.
`default_nettype none

package awl_pkg;
    // Command codes, both start the same single-sector write
    localparam logic [7:0] CMD_LONG_RETRY = 8'h32;
    localparam logic [7:0] CMD_LONG_NORETRY = 8'h33;

    // Data phase layout
    localparam int DATA_BYTES = 512;
    localparam int ECC_BYTES = 4;
    localparam int XFER_BYTES = DATA_BYTES + ECC_BYTES;
    localparam int BUF_AW = 10;
    localparam logic [BUF_AW-1:0] LAST_IDX = BUF_AW'(XFER_BYTES - 1);

    // Drive/head fields
    localparam int DH_LBA_BIT = 6;
    localparam int DH_DRV_BIT = 4;

    // Status bit positions
    localparam int ST_BSY = 7;
    localparam int ST_DRDY = 6;
    localparam int ST_DWF = 5;
    localparam int ST_DSC = 4;
    localparam int ST_DRQ = 3;
    localparam int ST_CORR = 2;
    localparam int ST_IDX = 1;
    localparam int ST_ERR = 0;

    // Error bit positions that this command may report
    localparam int ER_BBK = 7;
    localparam int ER_IDNF = 4;
    localparam int ER_AMNF = 0;

    // Reset values
    localparam logic [7:0] STATUS_RST = 8'h50;
    localparam logic [7:0] ERROR_RST = 8'h00;
    localparam logic [7:0] TF_RST = 8'h00;
endpackage : awl_pkg

`default_nettype wire

/* File: logic/awl_buf_if.sv */
// Port bundle between the command handler and its sector buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none

interface awl_buf_if;
    logic we;
    logic [awl_pkg::BUF_AW-1:0] waddr;
    logic [7:0] wdata;
    logic [awl_pkg::BUF_AW-1:0] raddr;
    logic [7:0] rdata;

    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : awl_buf_if

`default_nettype wire

/* File: logic/awl_sector_buf.sv */
// Sector buffer: one sector plus its check bytes, registered read.
// Reading an entry in the cycle it is written returns the byte it held before.
`timescale 1ns/10ps
`default_nettype none

module awl_sector_buf #(
    parameter int DEPTH = awl_pkg::XFER_BYTES
) (
    // Clock
    input wire logic clk,
    // Buffer access
    awl_buf_if.mem bus
);
    logic [7:0] mem_q [DEPTH];
    logic [7:0] rdata_q;

    always_ff @(posedge clk)
    begin
        if (bus.we)
        begin
            mem_q[bus.waddr] <= bus.wdata;
        end
        rdata_q <= mem_q[bus.raddr];
    end

    assign bus.rdata = rdata_q;
endmodule : awl_sector_buf

`default_nettype wire

/* File: tb/awl_checker.sv */
// Port assertions for the long-sector write handler.
// Bound into awl_top; sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module awl_checker (
    // Clock, reset, command
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic CMD_WR,
    input wire logic [7:0] CMD_CODE,
    // Results
    input wire logic FL_START,
    input wire logic FL_VALID,
    input wire logic [7:0] STATUS,
    input wire logic [7:0] ERROR,
    input wire logic [7:0] TF_SEC_CNT,
    input wire logic CMD_DONE
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    logic idle, code_ok;
    assign idle = !STATUS[7] && !STATUS[3];
    assign code_ok = CMD_CODE == 8'h32 || CMD_CODE == 8'h33;
    sequence s_take; CMD_WR && idle && code_ok; endsequence
    sequence s_burst; FL_VALID [*8]; endsequence
    a_take_drq: assert property (s_take |=> STATUS == 8'h58) else $error("no data request");
    a_bad_code: assert property (CMD_WR && idle && !code_ok |=> idle) else $error("bad code taken");
    a_fixed_bits: assert property (STATUS[6:4] == 3'h5 && !STATUS[2:1]) else $error("fixed bits");
    a_err_bits: assert property (!ERROR[6:5] && !ERROR[3:1]) else $error("error bits");
    a_done_stat: assert property (CMD_DONE |-> idle && STATUS[0] == |ERROR) else $error("done status");
    a_sec_cnt: assert property (CMD_DONE |-> TF_SEC_CNT == {7'h00, |ERROR}) else $error("sector count");
    a_stream_run: assert property (FL_START |-> ##2 s_burst) else $error("stream gap");
    a_start_busy: assert property (FL_START |-> STATUS == 8'hd0) else $error("start status");
endmodule : awl_checker
bind awl_top awl_checker u_chk (.CLK_SYS(CLK_SYS), .RST(RST), .CMD_WR(CMD_WR), .CMD_CODE(CMD_CODE),
    .FL_START(FL_START), .FL_VALID(FL_VALID), .STATUS(STATUS), .ERROR(ERROR), .TF_SEC_CNT(TF_SEC_CNT),
    .CMD_DONE(CMD_DONE));
`default_nettype wire

/* File: tb/awl_flash_model.sv */
// Flash side model: takes the byte stream, answers done after a delay.
// Assumes one byte per cycle on the handler's clock.
`timescale 1ns/10ps
`default_nettype none
module awl_flash_model (
    // Clock, stream
    input wire logic clk,
    input wire logic st,
    input wire logic vld,
    input wire logic [7:0] byt,
    // Bench control, answer
    input wire logic [2:0] err,
    input wire logic [2:0] dly,
    output logic done,
    output logic [2:0] ferr
);
    logic [7:0] got[$];
    int wait_q = 0;
    // Error levels only hold with done
    assign ferr = done ? err : ~err;
    initial done = 1'b0;
    always @(posedge clk) begin
        done <= wait_q == 1;
        if (wait_q > 0) wait_q <= wait_q - 1;
        if (st) got.delete();
        if (vld) got.push_back(byt);
        if (vld && got.size() == 516) wait_q <= dly + 1;
    end
endmodule : awl_flash_model
`default_nettype wire

/* File: tb/tb_top.sv */
// Bench: long-sector writes checked against a queue model.
// Needs the handler, its checker and the flash model.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, dv = 1'b0;
    logic [7:0] code = 8'h00, dh = 8'h00, ch = 8'h00, cl = 8'h00, sn = 8'h00, db = 8'h00;
    logic [2:0] err = 3'h0, dly = 3'h0, fe;
    logic st, lba, drv, fv, fd, done;
    logic [27:0] fa;
    logic [7:0] fb, stat, erv, tdh, tch, tcl, tsn, tsc, exp_q[$];
    int errors = 0, cmp_count = 0, seed = 72519, cyc = 0;
    always #25 clk = ~clk;
    awl_top uut (.CLK_SYS(clk), .RST(rst), .CMD_WR(wr), .CMD_CODE(code), .DEV_HEAD(dh), .CYL_HI(ch), .CYL_LO(cl),
        .SEC_NUM(sn), .DATA_VALID(dv), .DATA_BYTE(db), .FL_START(st), .FL_LBA(lba), .FL_DRIVE(drv), .FL_ADDR(fa),
        .FL_VALID(fv), .FL_BYTE(fb), .FL_DONE(fd), .FL_BAD_BLOCK(fe[2]), .FL_ID_NF(fe[1]), .FL_AM_NF(fe[0]),
        .STATUS(stat), .ERROR(erv), .TF_DEV_HEAD(tdh), .TF_CYL_HI(tch), .TF_CYL_LO(tcl), .TF_SEC_NUM(tsn),
        .TF_SEC_CNT(tsc), .CMD_DONE(done));
    awl_flash_model u_fl (.clk(clk), .st(st), .vld(fv), .byt(fb), .err(err), .dly(dly), .done(fd), .ferr(fe));
    task chk(input string nm, input logic [39:0] g, input logic [39:0] w);
        cmp_count++;
        if (g !== w) begin
            errors++;
            $display("[ERR] %s exp %h got %h", nm, w, g);
        end
    endtask : chk
    task end_sim;
        $display("errors %0d checks %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim
    always @(posedge clk) begin
        if (++cyc == 20000) begin
            errors++;
            end_sim();
        end
    end
    task automatic run(input logic [7:0] c, input logic [2:0] e);
        logic [31:0] a, v;
        int n = 0, k = 0;
        a = $random(seed);
        @(posedge clk);
        // No count pin; a host would load one here
        {wr, code, dh, ch, cl, sn} <= {1'b1, c, a};
        {err, dly} <= {e, a[2:0]};
        @(posedge clk);
        wr <= 1'b0;
        #1 chk("take", {stat, fa, lba, drv}, {8'h58, a[27:0], a[30], a[28]});
        exp_q.delete();
        while (n < 516) begin
            @(posedge clk);
            v = $random(seed);
            // Stray command and address changes during the data phase
            {dv, db, wr, sn} <= {v[8], v[7:0], n == 100, v[23:16]};
            if (v[8]) begin
                exp_q.push_back(v[7:0]);
                n++;
            end
        end
        @(posedge clk);
        dv <= 1'b1;
        #1 chk("busy", {stat, st}, {8'hd0, 1'b1});
        @(posedge clk);
        dv <= 1'b0;
        while (done !== 1'b1 && k < 2000) begin
            @(posedge clk);
            #1 k++;
        end
        chk("done", {stat, erv, tsc}, {7'h28, |e, e[2], 2'h0, e[1], 3'h0, e[0], 7'h00, |e});
        chk("last good", {tdh[6], tdh[3:0], tch, tcl, tsn}, {a[30], a[27:0]});
        chk("count", u_fl.got.size(), exp_q.size());
        foreach (exp_q[i]) chk("byte", u_fl.got[i], exp_q[i]);
    endtask : run
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        #1 chk("reset", {stat, erv, tsc}, {8'h50, 16'h0000});
        run(8'h32, 3'h0);
        run(8'h33, 3'h5);
        @(posedge clk);
        {wr, code} <= {1'b1, 8'h20};
        @(posedge clk);
        wr <= 1'b0;
        #1 chk("refused", stat, 8'h51);
        run(8'h32, 3'h2);
        run(8'h33, 3'h0);
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
